// [core/adrs_ctrl.sv]
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/100ps
// register block and routing control for the converter front end
module adrs_ctrl
  import adrs_pkg::*;
(
  input  wire logic              aclk,             // system clock
  input  wire logic              aresetn,          // sync reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,     // write address
  input  wire logic              s_axi_awvalid,    // write address valid
  output      logic              s_axi_awready,    // write address ready
  input  wire logic [31:0]       s_axi_wdata,      // write data
  input  wire logic [3:0]        s_axi_wstrb,      // write strobes
  input  wire logic              s_axi_wvalid,     // write data valid
  output      logic              s_axi_wready,     // write data ready
  output      logic [1:0]        s_axi_bresp,      // write response
  output      logic              s_axi_bvalid,     // write response valid
  input  wire logic              s_axi_bready,     // write response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,     // read address
  input  wire logic              s_axi_arvalid,    // read address valid
  output      logic              s_axi_arready,    // read address ready
  output      logic [31:0]       s_axi_rdata,      // read data
  output      logic [1:0]        s_axi_rresp,      // read response
  output      logic              s_axi_rvalid,     // read data valid
  input  wire logic              s_axi_rready,     // read data ready
  input  wire logic [NUM_CH-1:0] port_func_req,    // pin original function wanted
  input  wire logic [NUM_CH-1:0] port_pullup_req,  // pull-high programmed
  input  wire logic [NUM_CH-1:0] port_out_en_req,  // port direction output
  output      logic [NUM_CH-1:0] pad_func_en,      // original function active
  output      logic [NUM_CH-1:0] pad_pullup_en,    // pull-high connected
  output      logic [NUM_CH-1:0] pad_out_en,       // output driver enabled
  output      logic [NUM_CH-1:0] pad_analog_en,    // pin set as analog input
  output      logic [NUM_CH-1:0] an_switch_on,     // channel switch closed
  output      adrs_conv_in_t     conv_in_src,      // converter input source
  output      logic              conv_in_floating, // external source, no channel connected
  output      adrs_ref_route_t   ref_route,        // reference path controls
  output      logic              bandgap_enable    // bandgap circuit on
);
  // register state
  logic [3:0]        chan_sel_reg, chan_sel_next;
  logic [3:0]        src_sel_reg, src_sel_next;
  logic [7:0]        ref_amp_reg, ref_amp_next;
  logic [7:0]        bandgap_reg, bandgap_next;
  logic [NUM_CH-1:0] pin_analog_reg, pin_analog_next;
  // bus state
  logic              aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg, rdata_reg, rd_word, status_word;
  logic [3:0]        wstrb_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic              aw_take, w_take, ar_take, wr_fire, wr_hit, rd_hit;
  logic              wr_ctrl_a, wr_ctrl_b, wr_ref, wr_bg, wr_pin_lo, wr_pin_hi;
  adrs_in_route_t    in_route;

  // handshake readiness, one write and one read at a time
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign wr_fire       = aw_held_reg && w_held_reg;

  // write address decode
  assign wr_ctrl_a = wr_fire && (awaddr_reg == OFS_CTRL_A) && wstrb_reg[0];
  assign wr_ctrl_b = wr_fire && (awaddr_reg == OFS_CTRL_B) && wstrb_reg[0];
  assign wr_ref    = wr_fire && (awaddr_reg == OFS_REF_AMP) && wstrb_reg[0];
  assign wr_bg     = wr_fire && (awaddr_reg == OFS_BANDGAP) && wstrb_reg[0];
  assign wr_pin_lo = wr_fire && (awaddr_reg == OFS_PIN_ANALOG) && wstrb_reg[0];
  assign wr_pin_hi = wr_fire && (awaddr_reg == OFS_PIN_ANALOG) && wstrb_reg[1];
  assign wr_hit    = (awaddr_reg == OFS_CTRL_A) || (awaddr_reg == OFS_CTRL_B) ||
                     (awaddr_reg == OFS_REF_AMP) || (awaddr_reg == OFS_BANDGAP) ||
                     (awaddr_reg == OFS_PIN_ANALOG) || (awaddr_reg == OFS_STATUS);

  // register next values
  // channel, source, reference amplifier, bandgap and analog pin fields
  assign chan_sel_next = wr_ctrl_a ? wdata_reg[CHAN_LSB +: 4] : chan_sel_reg;
  assign src_sel_next  = wr_ctrl_b ? wdata_reg[SRC_LSB +: 4] : src_sel_reg;
  assign ref_amp_next  = wr_ref ? (wdata_reg[7:0] & REF_AMP_WMASK) : ref_amp_reg;
  assign bandgap_next  = wr_bg ? (wdata_reg[7:0] & BANDGAP_WMASK) : bandgap_reg;
  assign pin_analog_next[7:0] = wr_pin_lo ? wdata_reg[7:0] : pin_analog_reg[7:0];
  assign pin_analog_next[NUM_CH-1:8] = wr_pin_hi ? wdata_reg[NUM_CH-1:8]
                                                 : pin_analog_reg[NUM_CH-1:8];

  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chan_sel_reg   <= RST_FIELD;
      src_sel_reg    <= RST_FIELD;
      ref_amp_reg    <= RST_REF_AMP;
      bandgap_reg    <= RST_BANDGAP;
      pin_analog_reg <= RST_PIN_ANALOG;
    end else begin
      chan_sel_reg   <= chan_sel_next;
      src_sel_reg    <= src_sel_next;
      ref_amp_reg    <= ref_amp_next;
      bandgap_reg    <= bandgap_next;
      pin_analog_reg <= pin_analog_next;
    end
  end

  // write channel capture and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // live state for software
  assign status_word = {12'h000, ref_route.amp_in_pin_on, ref_route.ref_pin_on,
                        ref_route.conv_ref, 1'b0, in_route.src, 1'b0,
                        in_route.floating, in_route.chan_on};

  // read selection
  assign rd_word = (s_axi_araddr == OFS_CTRL_A)     ? {28'h0000000, chan_sel_reg} :
                   (s_axi_araddr == OFS_CTRL_B)     ? {24'h000000, src_sel_reg, 4'h0} :
                   (s_axi_araddr == OFS_REF_AMP)    ? {24'h000000, ref_amp_reg} :
                   (s_axi_araddr == OFS_BANDGAP)    ? {24'h000000, bandgap_reg} :
                   (s_axi_araddr == OFS_PIN_ANALOG) ? {22'h0, pin_analog_reg} :
                   (s_axi_araddr == OFS_STATUS)     ? status_word : 32'h00000000;
  assign rd_hit  = (s_axi_araddr == OFS_CTRL_A) || (s_axi_araddr == OFS_CTRL_B) ||
                   (s_axi_araddr == OFS_REF_AMP) || (s_axi_araddr == OFS_BANDGAP) ||
                   (s_axi_araddr == OFS_PIN_ANALOG) || (s_axi_araddr == OFS_STATUS);

  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= '0;
      rresp_reg  <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  adrs_input_route u_input_route (
    .src_sel  (src_sel_reg),
    .chan_sel (chan_sel_reg),
    .route    (in_route)
  );

  adrs_ref_route u_ref_route (
    .amp_ctrl (ref_amp_reg),
    .route    (ref_route)
  );

  assign an_switch_on     = in_route.chan_on;
  assign conv_in_src      = in_route.src;
  assign conv_in_floating = in_route.floating;
  assign bandgap_enable   = bandgap_reg[BG_EN_BIT];

  assign pad_analog_en = pin_analog_reg;
  assign pad_func_en   = port_func_req & ~pin_analog_reg;
  assign pad_pullup_en = port_pullup_req & ~pin_analog_reg;
  assign pad_out_en    = port_out_en_req & ~pin_analog_reg;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_amp_enable;
    wr_ref |=> ref_route.amp_en == $past(wdata_reg[AMP_EN_BIT]);
  endproperty
  a_amp_enable: assert property (p_amp_enable) else $error("amp enable not written");

  property p_ref_reserved;
    (ar_take && s_axi_araddr == OFS_REF_AMP) |=> s_axi_rvalid && s_axi_rdata[6:5] == 2'b00;
  endproperty
  a_ref_reserved: assert property (p_ref_reserved) else $error("reserved bits read one");

  property p_bg_cuts_pin;
    ref_amp_reg[AMP_IN_BIT] |-> ref_route.amp_in_bg_on && !ref_route.amp_in_pin_on;
  endproperty
  a_bg_cuts_pin: assert property (p_bg_cuts_pin) else $error("pin path left on");

  property p_conv_ref;
    (ref_amp_reg[3:2] != 2'b01) |-> !ref_route.ref_pin_on &&
      (ref_amp_reg[3] ? ref_route.conv_ref == REF_SRC_AMP
                      : ref_route.conv_ref == REF_SRC_SUPPLY);
  endproperty
  a_conv_ref: assert property (p_conv_ref) else $error("reference select wrong");

  property p_bg_read;
    (ar_take && s_axi_araddr == OFS_BANDGAP) |=>
      s_axi_rdata == {31'h0, $past(bandgap_reg[BG_EN_BIT])};
  endproperty
  a_bg_read: assert property (p_bg_read) else $error("bandgap read wrong");

  property p_internal_cuts;
    (!src_sel_reg[3] && src_sel_reg[1:0] != 2'b00) |-> an_switch_on == '0 && !conv_in_floating;
  endproperty
  a_internal_cuts: assert property (p_internal_cuts) else $error("channel on for internal");

  property p_ground;
    (src_sel_reg[3:2] == 2'b10) |-> conv_in_src == CONV_IN_GROUND && an_switch_on == '0;
  endproperty
  a_ground: assert property (p_ground) else $error("ground not selected");

  property p_chan_pick;
    (conv_in_src == CONV_IN_EXT && chan_sel_reg < 4'(NUM_CH)) |->
      an_switch_on == (10'h001 << chan_sel_reg);
  endproperty
  a_chan_pick: assert property (p_chan_pick) else $error("wrong channel switch");

  property p_chan_float;
    (conv_in_src == CONV_IN_EXT && chan_sel_reg > 4'h9) |-> conv_in_floating && an_switch_on == '0;
  endproperty
  a_chan_float: assert property (p_chan_float) else $error("floating not flagged");

  property p_pin_override;
    ((pad_pullup_en | pad_func_en | pad_out_en) & pin_analog_reg) == '0;
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("analog pin still digital");

  property p_write_effect;
    (wr_ctrl_a && wstrb_reg[0]) |=> chan_sel_reg == $past(wdata_reg[3:0]);
  endproperty
  a_write_effect: assert property (p_write_effect) else $error("channel write lost");

  property p_bresp;
    (aw_take && w_take) |=> ##1 s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");

  property p_amp_input;
    wr_ref |=> ref_route.amp_in_bg_on == $past(wdata_reg[AMP_IN_BIT]);
  endproperty
  a_amp_input: assert property (p_amp_input) else $error("amp input not written");

  property p_ref_code;
    wr_ref |=> ref_route.ref_pin_on == ($past(wdata_reg[CONV_REF_LSB +: 2]) == 2'b01);
  endproperty
  a_ref_code: assert property (p_ref_code) else $error("reference pin path wrong");

  property p_gain;
    wr_ref |=> ref_route.gain == adrs_gain_t'($past(wdata_reg[GAIN_LSB +: 2]));
  endproperty
  a_gain: assert property (p_gain) else $error("gain code not written");

  property p_bg_write;
    wr_bg |=> bandgap_enable == $past(wdata_reg[BG_EN_BIT]);
  endproperty
  a_bg_write: assert property (p_bg_write) else $error("bandgap enable not written");

  property p_dir_follow;
    pad_out_en == (port_out_en_req & ~pin_analog_reg);
  endproperty
  a_dir_follow: assert property (p_dir_follow) else $error("direction not overridden");

  property p_ext_codes;
    (src_sel_reg == 4'h0 || src_sel_reg == 4'h4 || src_sel_reg[3:2] == 2'b11) |->
      conv_in_src == CONV_IN_EXT;
  endproperty
  a_ext_codes: assert property (p_ext_codes) else $error("external source not chosen");

  property p_supply_taps;
    (src_sel_reg[3:2] == 2'b00 && src_sel_reg[1:0] != 2'b00) |->
      conv_in_src == (src_sel_reg[1] ? (src_sel_reg[0] ? CONV_IN_SUPPLY_QUARTER
                                                       : CONV_IN_SUPPLY_HALF)
                                     : CONV_IN_SUPPLY);
  endproperty
  a_supply_taps: assert property (p_supply_taps) else $error("supply tap wrong");

  property p_amp_taps;
    (src_sel_reg[3:2] == 2'b01 && src_sel_reg[1:0] != 2'b00) |->
      conv_in_src == (src_sel_reg[1] ? (src_sel_reg[0] ? CONV_IN_AMP_QUARTER
                                                       : CONV_IN_AMP_HALF)
                                     : CONV_IN_AMP);
  endproperty
  a_amp_taps: assert property (p_amp_taps) else $error("amplifier tap wrong");

  property p_chan_read;
    (ar_take && s_axi_araddr == OFS_CTRL_A) |=> s_axi_rdata == {28'h0, $past(chan_sel_reg)};
  endproperty
  a_chan_read: assert property (p_chan_read) else $error("channel field read wrong");

  c_ext_top: cover property (conv_in_src == CONV_IN_EXT && an_switch_on[NUM_CH-1]);
  c_ground: cover property (conv_in_src == CONV_IN_GROUND);
  c_amp_ref: cover property (ref_route.conv_ref == REF_SRC_AMP && ref_route.amp_in_bg_on);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_floating: cover property (conv_in_floating);
endmodule : adrs_ctrl

// [core/adrs_input_route.sv]
`timescale 1ns/100ps
// converter input multiplexer decode
module adrs_input_route
  import adrs_pkg::*;
(
  input  wire logic [3:0]     src_sel,   // input source field
  input  wire logic [3:0]     chan_sel,  // external channel field
  output adrs_in_route_t      route      // multiplexer controls
);
  adrs_conv_in_t src;
  logic          ext_sel;

  // source decode
  always_comb begin
    casez (src_sel)
      4'b0000, 4'b0100, 4'b11??: src = CONV_IN_EXT;
      4'b0001: src = CONV_IN_SUPPLY;
      4'b0010: src = CONV_IN_SUPPLY_HALF;
      4'b0011: src = CONV_IN_SUPPLY_QUARTER;
      4'b0101: src = CONV_IN_AMP;
      4'b0110: src = CONV_IN_AMP_HALF;
      4'b0111: src = CONV_IN_AMP_QUARTER;
      4'b10??: src = CONV_IN_GROUND;
      default: src = CONV_IN_EXT;
    endcase
  end

  assign ext_sel = (src == CONV_IN_EXT);

  // one switch per pin
  for (genvar i = 0; i < NUM_CH; i++) begin : g_chan
    assign route.chan_on[i] = ext_sel && (chan_sel == 4'(i));
  end

  assign route.floating = ext_sel && (chan_sel > 4'(NUM_CH - 1));
  assign route.src      = src;
endmodule : adrs_input_route

// [core/adrs_pkg.sv]
package adrs_pkg;
  localparam int          NUM_CH         = 10;
  localparam int          ADDR_W         = 8;
  // register byte addresses
  localparam logic [7:0]  OFS_CTRL_A     = 8'h00;
  localparam logic [7:0]  OFS_CTRL_B     = 8'h04;
  localparam logic [7:0]  OFS_REF_AMP    = 8'h08;
  localparam logic [7:0]  OFS_BANDGAP    = 8'h0c;
  localparam logic [7:0]  OFS_PIN_ANALOG = 8'h10;
  localparam logic [7:0]  OFS_STATUS     = 8'h14;
  // field positions
  localparam int          CHAN_LSB       = 0;
  localparam int          SRC_LSB        = 4;
  localparam int          AMP_EN_BIT     = 7;
  localparam int          AMP_IN_BIT     = 4;
  localparam int          CONV_REF_LSB   = 2;
  localparam int          GAIN_LSB       = 0;
  localparam int          BG_EN_BIT      = 0;
  localparam int          STAT_FLOAT_BIT = 10;
  localparam int          STAT_SRC_LSB   = 12;
  localparam int          STAT_REF_LSB   = 16;
  localparam int          STAT_REFPIN    = 18;
  localparam int          STAT_AMPPIN    = 19;
  // writable bits and reset values
  localparam logic [7:0]  REF_AMP_WMASK  = 8'h9f;
  localparam logic [7:0]  BANDGAP_WMASK  = 8'h01;
  localparam logic [3:0]  RST_FIELD      = 4'h0;
  localparam logic [7:0]  RST_REF_AMP    = 8'h00;
  localparam logic [7:0]  RST_BANDGAP    = 8'h00;
  localparam logic [9:0]  RST_PIN_ANALOG = 10'h000;
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {REF_SRC_SUPPLY, REF_SRC_PIN, REF_SRC_AMP} adrs_conv_ref_t;
  typedef enum logic [1:0] {GAIN_X1, GAIN_X1P667, GAIN_X2P5, GAIN_X3P333} adrs_gain_t;
  typedef enum logic [2:0] {
    CONV_IN_EXT, CONV_IN_SUPPLY, CONV_IN_SUPPLY_HALF, CONV_IN_SUPPLY_QUARTER,
    CONV_IN_AMP, CONV_IN_AMP_HALF, CONV_IN_AMP_QUARTER, CONV_IN_GROUND
  } adrs_conv_in_t;

  // reference path switch controls
  typedef struct packed {
    logic           amp_en;
    logic           amp_in_pin_on;
    logic           amp_in_bg_on;
    adrs_gain_t     gain;
    adrs_conv_ref_t conv_ref;
    logic           ref_pin_on;
  } adrs_ref_route_t;

  // converter input switch controls
  typedef struct packed {
    adrs_conv_in_t     src;
    logic [NUM_CH-1:0] chan_on;
    logic              floating;
  } adrs_in_route_t;
endpackage : adrs_pkg

// [core/adrs_ref_route.sv]
`timescale 1ns/100ps
// reference amplifier and converter reference decode
module adrs_ref_route
  import adrs_pkg::*;
(
  input  wire logic [7:0]     amp_ctrl,   // amplifier control register
  output adrs_ref_route_t     route       // reference switch controls
);
  logic [1:0] ref_code;

  assign ref_code = amp_ctrl[CONV_REF_LSB +: 2];
  assign route.amp_en        = amp_ctrl[AMP_EN_BIT];
  assign route.amp_in_bg_on  = amp_ctrl[AMP_IN_BIT];
  assign route.amp_in_pin_on = !amp_ctrl[AMP_IN_BIT];
  assign route.gain          = adrs_gain_t'(amp_ctrl[GAIN_LSB +: 2]);
  assign route.conv_ref      = ref_code[1] ? REF_SRC_AMP :
                               (ref_code[0] ? REF_SRC_PIN : REF_SRC_SUPPLY);
  assign route.ref_pin_on    = (ref_code == 2'b01);
endmodule : adrs_ref_route

// [testbench/adrs_ctrl_tb.sv]
`timescale 1ns/100ps
// table-driven regression for the converter front-end control block
module adrs_ctrl_tb
  import adrs_pkg::*;
;
  typedef struct packed {
    logic [3:0] src;
    logic [3:0] chan;
    logic [2:0] isrc;
    logic [9:0] on;
    logic       flt;
  } adrs_row_t;

  logic              aclk;
  logic              aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  logic [NUM_CH-1:0] func_req, pull_req, oe_req;
  logic [NUM_CH-1:0] func_en, pull_en, oe_en, ana_en, sw_on;
  adrs_conv_in_t     conv_src;
  logic              conv_flt, bg_en;
  adrs_ref_route_t   ref_rt;
  int                miscompares, n_tests;

  // source code, channel code, expected source, switches, floating
  adrs_row_t rows [16] = '{
    '{4'h0, 4'h3, 3'h0, 10'h008, 1'h0}, '{4'h1, 4'h3, 3'h1, 10'h000, 1'h0},
    '{4'h2, 4'h5, 3'h2, 10'h000, 1'h0}, '{4'h3, 4'h5, 3'h3, 10'h000, 1'h0},
    '{4'h4, 4'h9, 3'h0, 10'h200, 1'h0}, '{4'h5, 4'h9, 3'h4, 10'h000, 1'h0},
    '{4'h6, 4'h0, 3'h5, 10'h000, 1'h0}, '{4'h7, 4'h0, 3'h6, 10'h000, 1'h0},
    '{4'h8, 4'h2, 3'h7, 10'h000, 1'h0}, '{4'h9, 4'hc, 3'h7, 10'h000, 1'h0},
    '{4'ha, 4'h4, 3'h7, 10'h000, 1'h0}, '{4'hb, 4'h7, 3'h7, 10'h000, 1'h0},
    '{4'hc, 4'h0, 3'h0, 10'h001, 1'h0}, '{4'hd, 4'ha, 3'h0, 10'h000, 1'h1},
    '{4'he, 4'hf, 3'h0, 10'h000, 1'h1}, '{4'hf, 4'h1, 3'h0, 10'h002, 1'h0}
  };

  // device under test
  adrs_ctrl u_adrs_ctrl (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_func_req(func_req), .port_pullup_req(pull_req), .port_out_en_req(oe_req),
    .pad_func_en(func_en), .pad_pullup_en(pull_en), .pad_out_en(oe_en),
    .pad_analog_en(ana_en), .an_switch_on(sw_on), .conv_in_src(conv_src),
    .conv_in_floating(conv_flt), .ref_route(ref_rt), .bandgap_enable(bg_en)
  );

  // 20 mhz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // verdict and end of run
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] er);
    bit aw_ok, w_ok, done;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    done  = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
      done = (bvalid === 1'b1);
      if (done)
        chk({30'h0, bresp}, {30'h0, er});
    end
    bready <= 1'b0;
  endtask : axi_wr

  // axi4-lite read with data and response compare
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit ar_ok, done;
    ar_ok = 1'b0;
    done  = 1'b0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (!ar_ok && arready === 1'b1) begin
        ar_ok = 1'b1;
        arvalid <= 1'b0;
      end
      done = (rvalid === 1'b1);
      if (done) begin
        chk(rdata, exp);
        chk({30'h0, rresp}, {30'h0, er});
      end
    end
    rready <= 1'b0;
  endtask : rd_chk

  // main sequence
  initial begin
    miscompares = 0;
    n_tests     = 0;
    aresetn     = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    func_req = 10'h3ff;
    pull_req = 10'h0f0;
    oe_req   = 10'h30c;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFS_CTRL_A, 32'h0, RESP_OKAY);
    rd_chk(OFS_REF_AMP, 32'h0, RESP_OKAY);
    rd_chk(OFS_BANDGAP, 32'h0, RESP_OKAY);
    rd_chk(OFS_STATUS, 32'h0008_0001, RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      axi_wr(OFS_CTRL_B, {24'h0, rows[i].src, 4'hf}, 4'h1, RESP_OKAY);
      axi_wr(OFS_CTRL_A, {24'h0, 4'hf, rows[i].chan}, 4'h1, RESP_OKAY);
      chk({22'h0, sw_on}, {22'h0, rows[i].on});
      chk({29'h0, conv_src}, {29'h0, rows[i].isrc});
      chk({31'h0, conv_flt}, {31'h0, rows[i].flt});
      rd_chk(OFS_STATUS, {12'h0, 4'h8, 1'h0, rows[i].isrc, 1'h0, rows[i].flt, rows[i].on},
             RESP_OKAY);
    end
    rd_chk(OFS_CTRL_A, 32'h1, RESP_OKAY);
    rd_chk(OFS_CTRL_B, 32'hf0, RESP_OKAY);
    // reference codes, reference pins taken as freed
    for (int i = 0; i < 4; i++) begin
      axi_wr(OFS_REF_AMP, {28'h0, i[1:0], i[1:0]}, 4'h1, RESP_OKAY);
      chk({24'h0, ref_rt}, {24'h0, 3'h2, i[1:0], (i > 1) ? 2'h2 : i[1:0], i == 1});
    end
    axi_wr(OFS_BANDGAP, 32'hff, 4'h1, RESP_OKAY);
    rd_chk(OFS_BANDGAP, 32'h1, RESP_OKAY);
    chk({31'h0, bg_en}, 32'h1);
    repeat (4) @(posedge aclk);
    axi_wr(OFS_REF_AMP, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd_chk(OFS_REF_AMP, 32'h9f, RESP_OKAY);
    chk({24'h0, ref_rt}, {24'h0, 8'hbc});
    axi_wr(OFS_REF_AMP, 32'h0, 4'he, RESP_OKAY);
    rd_chk(OFS_REF_AMP, 32'h9f, RESP_OKAY);
    axi_wr(OFS_PIN_ANALOG, 32'h155, 4'h3, RESP_OKAY);
    chk({22'h0, ana_en}, 32'h155);
    chk({22'h0, func_en}, 32'h2aa);
    chk({22'h0, pull_en}, 32'h0a0);
    chk({22'h0, oe_en}, 32'h208);
    @(posedge aclk);
    oe_req <= 10'h3ff;
    @(posedge aclk);
    chk({22'h0, oe_en}, 32'h2aa);
    axi_wr(8'h18, 32'hff, 4'hf, RESP_SLVERR);
    rd_chk(8'h18, 32'h0, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'h0, 4'hf, RESP_OKAY);
    rd_chk(OFS_STATUS, 32'h0002_0002, RESP_OKAY);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(OFS_PIN_ANALOG, 32'h0, RESP_OKAY);
    rd_chk(OFS_STATUS, 32'h0008_0001, RESP_OKAY);
    chk({22'h0, func_en}, 32'h3ff);
    summarize();
  end

  // watchdog against a hung handshake
  initial begin
    #150000;
    miscompares++;
    summarize();
  end
endmodule : adrs_ctrl_tb
